// ===== rtl/einf_pkg.sv
// Constants and types shared by the external interrupt noise filter.
`default_nettype none
package einf_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] FILT_CTRL_ADDR = 32'hFFFFF318;
   localparam logic [31:0] RISE_A_ADDR = 32'hFFFFF320;
   localparam logic [31:0] FALL_A_ADDR = 32'hFFFFF321;
   localparam logic [31:0] RISE_B_ADDR = 32'hFFFFF322;
   localparam logic [31:0] FALL_B_ADDR = 32'hFFFFF323;
   localparam logic [31:0] RISE_C_ADDR = 32'hFFFFF324;
   localparam logic [31:0] FALL_C_ADDR = 32'hFFFFF325;
   localparam logic [31:0] STAT_ADDR   = 32'hFFFFF326;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [7:0] FILT_CTRL_MASK = 8'hC7;
   localparam int         FILT_TYPE_BIT = 7;
   localparam int         SAMP_CNT_BIT  = 6;
   localparam int         CLK_SEL_MSB   = 2;
   localparam int         NMI_BIT_A     = 2;
   localparam int         PIN3_BIT_A    = 6;
   localparam int         PIN7_BIT_B    = 1;
   localparam int         PIN4_BIT_C    = 5;
   localparam int         PIN6_BIT_C    = 7;
   localparam int         STAT_LVL_BIT  = 0;
   localparam int         STAT_RUN_BIT  = 1;

   // ----------------------------------------------------------------
   // Sampling clock selection
   // ----------------------------------------------------------------
   localparam logic [2:0] CLK_SEL_DIV64   = 3'h0;
   localparam logic [2:0] CLK_SEL_DIV1024 = 3'h4;
   localparam logic [2:0] CLK_SEL_SUB     = 3'h5;
   localparam int         DIV64_CYCLES    = 64;
   localparam int         SAMPLE_DIV_W    = 10;
   localparam int         SAMP_MAX        = 3;
   localparam int         PIN_COUNT       = 9;

   typedef enum logic [1:0] {
      EINF_EDGE_NONE,
      EINF_EDGE_RISE,
      EINF_EDGE_FALL,
      EINF_EDGE_BOTH
   } einf_edge_t;

endpackage : einf_pkg
`default_nettype wire

// ===== rtl/einf_filt_if.sv
// Link between the sample tick source, the digital filter and the top.
`timescale 1ns/10ps
`default_nettype none
interface einf_filt_if;
   logic tick;
   logic count_sel;
   logic pin;
   logic level;
   modport gen  (output tick);
   modport filt (input tick, input count_sel, input pin, output level);
   modport ctrl (input tick, input level, output count_sel, output pin);
endinterface : einf_filt_if
`default_nettype wire

// ===== rtl/einf_sample_tick.sv
// Sampling tick generator for the digital noise eliminator.
`timescale 1ns/10ps
`default_nettype none
module einf_sample_tick
   import einf_pkg::*;
#(
   parameter int DIV_W = SAMPLE_DIV_W
)(
   input  wire logic       core_clk_i,   // Main clock.
   input  wire logic       rst_n_i,      // Async reset, low.
   input  wire logic [2:0] clk_sel_i,    // Sampling clock code.
   input  wire logic       standby_i,    // IDLE or STOP active.
   input  wire logic       sub_clock_i,  // Subclock level.
   einf_filt_if.gen        fif           // Tick out.
);

   logic [DIV_W-1:0] div_cnt;
   logic             sub_prev;

   function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
      return DIV_W'((DIV64_CYCLES << sel) - 1);
   endfunction : div_mask

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub_prev <= 1'b0;
      end else begin
         sub_prev <= sub_clock_i;
      end
   end

   // The main-clock taps halt in standby; the subclock keeps sampling.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fif.tick <= 1'b0;
      end else if (clk_sel_i == CLK_SEL_SUB) begin
         fif.tick <= sub_clock_i & ~sub_prev;
      end else if (clk_sel_i <= CLK_SEL_DIV1024) begin
         fif.tick <= ~standby_i & ((div_cnt & div_mask(clk_sel_i)) == div_mask(clk_sel_i));
      end else begin
         fif.tick <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_STANDBY_HALT: assert property (
      standby_i && clk_sel_i <= CLK_SEL_DIV1024 |=> !fif.tick)
      else $error("Sampling tick while standby with main clock tap.");

   AST_SUB_RUNS: assert property (
      clk_sel_i == CLK_SEL_SUB && $rose(sub_clock_i) |=> fif.tick)
      else $error("Subclock edge gave no sampling tick.");

   AST_DIV_SPACING: assert property (
      fif.tick && $past(clk_sel_i) == CLK_SEL_DIV64 |->
      ##1 (!fif.tick || $past(clk_sel_i) == CLK_SEL_SUB)[*8])
      else $error("Divided sampling ticks too close together.");

endmodule : einf_sample_tick
`default_nettype wire

// ===== rtl/einf_digital_filter.sv
// Digital noise eliminator: level follows only agreeing consecutive samples.
`timescale 1ns/10ps
`default_nettype none
module einf_digital_filter
   import einf_pkg::*;
(
   input  wire logic core_clk_i,  // Main clock.
   input  wire logic rst_n_i,     // Async reset, low.
   einf_filt_if.filt fif          // Tick, pin, level.
);

   logic [SAMP_MAX-1:0] samp;
   logic [SAMP_MAX-1:0] next_samp;

   function automatic logic agree(input logic [SAMP_MAX-1:0] s, input logic two);
      return two ? (s[1] == s[0]) : (s[2] == s[1] && s[1] == s[0]);
   endfunction : agree

   assign next_samp = {samp[SAMP_MAX-2:0], fif.pin};

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp <= '0;
      end else if (fif.tick) begin
         samp <= next_samp;
      end
   end

   // A pulse seen by fewer than M samples can never move the level.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fif.level <= 1'b0;
      end else if (fif.tick && agree(next_samp, fif.count_sel)) begin
         fif.level <= next_samp[0];
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_LEVEL_ON_TICK: assert property (
      $changed(fif.level) |-> $past(fif.tick))
      else $error("Filtered level moved without a sample.");

   AST_THREE_AGREE: assert property (
      fif.tick && !fif.count_sel && next_samp == 3'h7 |=> fif.level)
      else $error("Three high samples did not set the level.");

   AST_TWO_AGREE: assert property (
      fif.tick && fif.count_sel && next_samp[1:0] == 2'h0 |=> !fif.level)
      else $error("Two low samples did not clear the level.");

endmodule : einf_digital_filter
`default_nettype wire

// ===== rtl/einf_top.sv
// External interrupt edge detection and noise filter, top level.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module einf_top
   import einf_pkg::*;
(
   input  wire logic        core_clk_i,              // 40 MHz main clock.
   input  wire logic        rst_n_i,                 // Async reset, low.
   input  wire logic [31:0] addr_i,                  // Register byte address.
   input  wire logic [7:0]  wdata_i,                 // Write data.
   input  wire logic        wr_stb_i,                // Write strobe.
   input  wire logic        rd_stb_i,                // Read strobe.
   output logic      [7:0]  rdata_o,                 // Read data, next cycle.
   input  wire logic        nmi_pin_i,               // Non-maskable pin.
   input  wire logic [7:0]  intp_pin_i,              // Maskable pins 0 to 7.
   input  wire logic        sub_clock_i,             // Subclock level.
   input  wire logic        idle_mode_i,             // IDLE mode active.
   input  wire logic        stop_mode_i,             // STOP mode active.
   output logic             nmi_req_o,               // NMI request pulse.
   output logic      [7:0]  intp_req_o               // Maskable request pulses.
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] noise_filter_control;
   logic [7:0] ext_int_rise_select_a;
   logic [7:0] ext_int_fall_select_a;
   logic [7:0] ext_int_rise_select_b;
   logic [7:0] ext_int_fall_select_b;
   logic [7:0] ext_int_rise_select_c;
   logic [7:0] ext_int_fall_select_c;

   logic                 filter_type_select;
   logic                 sample_count_select;
   logic [2:0]           sample_clock_sel;
   logic                 filtered_interrupt_pin;
   logic                 sampling_active;
   logic [PIN_COUNT-1:0] rising_sel;
   logic [PIN_COUNT-1:0] falling_sel;
   logic [PIN_COUNT-1:0] pin_src;
   logic [PIN_COUNT-1:0] pin_prev;
   logic [PIN_COUNT-1:0] edge_hit;
   logic [7:0]           next_rdata;
   logic [7:0]           status;

   einf_filt_if fif ();

   assign filter_type_select  = noise_filter_control[FILT_TYPE_BIT];
   assign sample_count_select = noise_filter_control[SAMP_CNT_BIT];
   assign sample_clock_sel    = noise_filter_control[CLK_SEL_MSB:0];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Single-bit updates reach these as read-modify-write byte stores.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         noise_filter_control  <= REG_RESET;
         ext_int_rise_select_a <= REG_RESET;
         ext_int_fall_select_a <= REG_RESET;
         ext_int_rise_select_b <= REG_RESET;
         ext_int_fall_select_b <= REG_RESET;
         ext_int_rise_select_c <= REG_RESET;
         ext_int_fall_select_c <= REG_RESET;
      end else if (wr_stb_i) begin
         case (addr_i)
            FILT_CTRL_ADDR: noise_filter_control <= wdata_i & FILT_CTRL_MASK;
            RISE_A_ADDR: ext_int_rise_select_a <= wdata_i;
            FALL_A_ADDR: ext_int_fall_select_a <= wdata_i;
            RISE_B_ADDR: ext_int_rise_select_b <= wdata_i;
            FALL_B_ADDR: ext_int_fall_select_b <= wdata_i;
            RISE_C_ADDR: ext_int_rise_select_c <= wdata_i;
            FALL_C_ADDR: ext_int_fall_select_c <= wdata_i;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Sampling is reported active only for a legal code not halted by standby.
   assign sampling_active = (sample_clock_sel == CLK_SEL_SUB) ||
                            (sample_clock_sel <= CLK_SEL_DIV1024 &&
                             !(idle_mode_i || stop_mode_i));

   always_comb begin
      status               = 8'h00;
      status[STAT_LVL_BIT] = fif.level;
      status[STAT_RUN_BIT] = sampling_active & filter_type_select;
   end

   always_comb begin
      case (addr_i)
         FILT_CTRL_ADDR: next_rdata = noise_filter_control;
         RISE_A_ADDR: next_rdata = ext_int_rise_select_a;
         FALL_A_ADDR: next_rdata = ext_int_fall_select_a;
         RISE_B_ADDR: next_rdata = ext_int_rise_select_b;
         FALL_B_ADDR: next_rdata = ext_int_fall_select_b;
         RISE_C_ADDR: next_rdata = ext_int_rise_select_c;
         FALL_C_ADDR: next_rdata = ext_int_fall_select_c;
         STAT_ADDR:   next_rdata = status;
         default:     next_rdata = 8'h00;
      endcase
   end

   // Read data stands for one cycle only, then returns to zero.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_stb_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Digital noise eliminator
   // ----------------------------------------------------------------
   assign fif.pin       = intp_pin_i[3];
   assign fif.count_sel = sample_count_select;

   einf_sample_tick u_tick (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .clk_sel_i   (sample_clock_sel),
      .standby_i   (idle_mode_i | stop_mode_i),
      .sub_clock_i (sub_clock_i),
      .fif         (fif)
   );

   einf_digital_filter u_filt (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .fif        (fif)
   );

   // The analog eliminator sits at the pad, so its output arrives as the pin.
   // Changing the filter type can itself look like an edge; software should
   // disable detection on that pin while switching.
   assign filtered_interrupt_pin = filter_type_select ? fif.level
                                                      : intp_pin_i[3];

   // ----------------------------------------------------------------
   // Edge selection map
   // ----------------------------------------------------------------
   // Index 0 is the NMI pin, indices 1 to 8 are maskable pins 0 to 7.
   assign rising_sel  = {ext_int_rise_select_b[PIN7_BIT_B],
                         ext_int_rise_select_c[PIN6_BIT_C:PIN4_BIT_C],
                         ext_int_rise_select_a[PIN3_BIT_A:NMI_BIT_A]};
   assign falling_sel = {ext_int_fall_select_b[PIN7_BIT_B],
                         ext_int_fall_select_c[PIN6_BIT_C:PIN4_BIT_C],
                         ext_int_fall_select_a[PIN3_BIT_A:NMI_BIT_A]};

   assign pin_src = {intp_pin_i[7:4], filtered_interrupt_pin,
                     intp_pin_i[2:0], nmi_pin_i};

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   function automatic logic edge_valid(input einf_edge_t mode,
                                       input logic       now,
                                       input logic       was);
      logic hit;
      hit = 1'b0;
      unique case (mode)
         EINF_EDGE_NONE: hit = 1'b0;
         EINF_EDGE_RISE: hit = now & ~was;
         EINF_EDGE_FALL: hit = ~now & was;
         EINF_EDGE_BOTH: hit = now ^ was;
      endcase
      return hit;
   endfunction : edge_valid

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_prev <= '0;
      end else begin
         pin_prev <= pin_src;
      end
   end

   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         edge_hit[i] = edge_valid(einf_edge_t'({falling_sel[i], rising_sel[i]}),
                                  pin_src[i], pin_prev[i]);
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nmi_req_o  <= 1'b0;
         intp_req_o <= 8'h00;
      end else begin
         nmi_req_o  <= edge_hit[0];
         intp_req_o <= edge_hit[PIN_COUNT-1:1];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_pin0_rise_only;
      ext_int_rise_select_a[3] && !ext_int_fall_select_a[3];
   endsequence

   sequence s_pin0_rose;
      s_pin0_rise_only ##0 $rose(intp_pin_i[0]);
   endsequence

   AST_ANALOG_PATH: assert property (
      !filter_type_select && ext_int_rise_select_a[PIN3_BIT_A] &&
      $rose(intp_pin_i[3]) |=> intp_req_o[3])
      else $error("Analog path edge on filtered pin was lost.");

   AST_DIGITAL_PATH: assert property (
      filter_type_select && $stable(fif.level) |=> !intp_req_o[3])
      else $error("Digital path raised a request without a level change.");

   AST_NMI_QUIET: assert property (
      !ext_int_rise_select_a[NMI_BIT_A] && !ext_int_fall_select_a[NMI_BIT_A]
      |=> !nmi_req_o)
      else $error("NMI request with no edge selected.");

   AST_RISE_ONLY: assert property (
      s_pin0_rose |=> intp_req_o[0])
      else $error("Rising edge on pin 0 gave no request.");

   AST_RISE_IGNORES_FALL: assert property (
      s_pin0_rise_only ##0 $fell(intp_pin_i[0]) |=> !intp_req_o[0])
      else $error("Falling edge accepted with rising only.");

   AST_ONE_PULSE: assert property (
      s_pin0_rose ##1 s_pin0_rise_only |=> !intp_req_o[0])
      else $error("Request on pin 0 lasted more than one cycle.");

   AST_MAP_B_BOTH: assert property (
      ext_int_rise_select_b[PIN7_BIT_B] && ext_int_fall_select_b[PIN7_BIT_B] &&
      $changed(intp_pin_i[7]) |=> intp_req_o[7])
      else $error("Pin 7 both-edge change gave no request.");

   AST_MAP_C_FALL: assert property (
      ext_int_fall_select_c[PIN4_BIT_C] && $fell(intp_pin_i[4]) |=> intp_req_o[4])
      else $error("Pin 4 falling edge gave no request.");

   AST_NONE_SILENT: assert property (
      rising_sel == '0 && falling_sel == '0 |=> nmi_req_o == 1'b0 && intp_req_o == 8'h00)
      else $error("Request raised with all detection off.");

   AST_READ_FILT_CTRL: assert property (
      rd_stb_i && addr_i == FILT_CTRL_ADDR |=>
      rdata_o == $past(noise_filter_control) && rdata_o[5:3] == 3'h0)
      else $error("Filter control read back wrong.");

   AST_READ_IDLE: assert property (
      !$past(rd_stb_i) |-> rdata_o == 8'h00)
      else $error("Read data stood outside the cycle after a read.");

   AST_NMI_BOTH: assert property (
      ext_int_rise_select_a[NMI_BIT_A] && ext_int_fall_select_a[NMI_BIT_A] &&
      $changed(nmi_pin_i) |=> nmi_req_o)
      else $error("NMI both-edge change gave no request.");

   AST_MAP_C_RISE: assert property (
      ext_int_rise_select_c[PIN6_BIT_C] && $rose(intp_pin_i[6]) |=> intp_req_o[6])
      else $error("Pin 6 rising edge gave no request.");

   AST_MAP_A_FALL: assert property (
      ext_int_fall_select_a[NMI_BIT_A + 3] && $fell(intp_pin_i[2]) |=> intp_req_o[2])
      else $error("Pin 2 falling edge gave no request.");

   // The previous filter type is required so a type switch cannot pose as an edge.
   AST_FILT_EDGE: assert property (
      filter_type_select && $past(filter_type_select) &&
      ext_int_rise_select_a[PIN3_BIT_A] && $rose(fif.level) |=> intp_req_o[3])
      else $error("Filtered level rise gave no request.");

endmodule : einf_top
`default_nettype wire

// ===== dv/einf_pin_src.sv
// Model of the external sources that drive the interrupt pins.
`timescale 1ns/10ps
`default_nettype none
module einf_pin_src (
   input  wire logic       core_clk_i,  // Main clock.
   output logic            nmi_pin_o,   // Non-maskable pin level.
   output logic      [7:0] intp_pin_o   // Maskable pin levels.
);
   logic [8:0] lvl = 9'h000;

   assign nmi_pin_o  = lvl[0];
   assign intp_pin_o = lvl[8:1];

   // Index 0 is the non-maskable pin, 1 to 8 are maskable pins 0 to 7.
   // Callers choose the width; on the filtered pin a width above M periods
   // is what guarantees a detection, shorter ones test rejection.
   task automatic pulse(input int idx, input int width);
      @(posedge core_clk_i);
      lvl <= lvl | (9'h001 << idx);
      repeat (width) @(posedge core_clk_i);
      lvl <= lvl & ~(9'h001 << idx);
   endtask : pulse
endmodule : einf_pin_src
`default_nettype wire

// ===== dv/einf_top_tb.sv
// Self-checking testbench for the external interrupt noise filter.
`timescale 1ns/10ps
`default_nettype none
module einf_top_tb;
   import einf_pkg::*;
   logic        core_clk     = 1'b0;
   logic        rst_n        = 1'b0;
   logic [31:0] addr         = 32'h0;
   logic [7:0]  wdata        = 8'h00;
   logic        wr_stb       = 1'b0;
   logic        rd_stb       = 1'b0;
   logic        sub_clock    = 1'b0;
   logic        idle_mode    = 1'b0;
   logic        stop_mode    = 1'b0;
   logic [7:0]  rdata;
   logic        nmi_pin;
   logic [7:0]  intp_pin;
   logic        nmi_req;
   logic [7:0]  intp_req;
   wire  [8:0]  reqv         = {intp_req, nmi_req};
   logic [7:0]  shadow [6];
   logic [31:0] addrs [7]    = '{FILT_CTRL_ADDR, RISE_A_ADDR, FALL_A_ADDR, RISE_B_ADDR,
                                 FALL_B_ADDR, RISE_C_ADDR, FALL_C_ADDR};
   int          cnt [9]      = '{default: 0};
   int          base [9];
   int          sub_div      = 0;
   int          err_total    = 0;
   int          total_checks = 0;

   einf_top u_einf_top (
      .core_clk_i (core_clk), .rst_n_i (rst_n), .addr_i (addr), .wdata_i (wdata),
      .wr_stb_i (wr_stb), .rd_stb_i (rd_stb), .rdata_o (rdata), .nmi_pin_i (nmi_pin),
      .intp_pin_i (intp_pin), .sub_clock_i (sub_clock), .idle_mode_i (idle_mode),
      .stop_mode_i (stop_mode), .nmi_req_o (nmi_req), .intp_req_o (intp_req));

   einf_pin_src u_einf_pin_src (
      .core_clk_i (core_clk), .nmi_pin_o (nmi_pin), .intp_pin_o (intp_pin));

   always #12.5 core_clk = ~core_clk;

   // Subclock of 32 main cycles, so T is known exactly in the standby test.
   always @(posedge core_clk) begin
      sub_div <= (sub_div + 1) % 16;
      if (sub_div == 15) begin
         sub_clock <= ~sub_clock;
      end
   end

   always @(posedge core_clk) begin
      for (int i = 0; i < 9; i++) begin
         if (rst_n && reqv[i] === 1'b1) begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Requests expected from one pulse: one per selected edge direction.
   function automatic int exp_edges(input logic [1:0] mode);
      return int'(mode[0]) + int'(mode[1]);
   endfunction : exp_edges

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge core_clk);
      wr_stb <= 1'b1;
      addr   <= a;
      wdata  <= d;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [7:0] d);
      @(posedge core_clk);
      rd_stb <= 1'b1;
      addr   <= a;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   // Index 0 is the non-maskable pin, 1 to 8 are maskable pins 0 to 7.
   task automatic set_mode(input int idx, input logic [1:0] m);
      for (int k = 0; k < 6; k++) begin
         shadow[k] = 8'h00;
      end
      if (idx <= 4) begin
         {shadow[1][idx + 2], shadow[0][idx + 2]} = m;
      end else if (idx <= 7) begin
         {shadow[5][idx], shadow[4][idx]} = m;
      end else begin
         {shadow[3][1], shadow[2][1]} = m;
      end
      for (int k = 0; k < 6; k++) begin
         wr(addrs[k + 1], shadow[k]);
      end
   endtask : set_mode

   task automatic pulse_chk(input int idx, input int width, input int waitc, input int e);
      int others;
      others = 0;
      base = cnt;
      u_einf_pin_src.pulse(idx, width);
      repeat (waitc) @(posedge core_clk);
      for (int j = 0; j < 9; j++) begin
         if (j != idx) begin
            others += cnt[j] - base[j];
         end
      end
      chk(cnt[idx] - base[idx], e);
      chk(others, 0);
   endtask : pulse_chk

   // Filtered pin is index 4; waits long enough for M samples and the edge.
   task automatic filt(input logic [2:0] code, input logic cbit, input int tper,
                       input int width, input int e);
      int m;
      m = cbit ? 2 : 3;
      wr(FILT_CTRL_ADDR, {1'b1, cbit, 3'b000, code});
      repeat (4 * tper) @(posedge core_clk);
      pulse_chk(4, width, (m + 2) * tper + 8, e);
   endtask : filt

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [7:0] r;
      int         t;
      int         mm;
      void'($urandom(32'h886a71a9));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      pulse_chk(0, 3, 4, 0);
      foreach (addrs[k]) begin
         rd(addrs[k], d);
         chk(d, REG_RESET);
         r = 8'($urandom);
         wr(addrs[k], r);
         rd(addrs[k], d);
         chk(d, r & ((k == 0) ? FILT_CTRL_MASK : 8'hFF));
         wr(addrs[k], 8'h00);
      end
      wr(32'hFFFFF330, 8'hA5);
      rd(32'hFFFFF330, d);
      chk(d, 8'h00);
      wr(STAT_ADDR, 8'hFF);
      rd(STAT_ADDR, d);
      chk(d, 8'h00);
      for (int i = 0; i < 9; i++) begin
         for (int m = 0; m < 4; m++) begin
            set_mode(i, 2'(m));
            pulse_chk(i, $urandom_range(4, 1), 4, exp_edges(2'(m)));
         end
      end
      set_mode(0, 2'b00);
      set_mode(4, EINF_EDGE_RISE);
      for (int c = 0; c < 5; c++) begin
         t  = 64 << c;
         mm = c[0] ? 2 : 3;
         filt(3'(c), c[0], t, (mm - 1) * t - 2, 0);
         filt(3'(c), c[0], t, mm * t + 2, 1);
      end
      filt(3'h6, 1'b0, 64, 8 * 64, 0);
      idle_mode <= 1'b1;
      filt(3'h0, 1'b0, 64, 4 * 64, 0);
      rd(STAT_ADDR, d);
      chk(d, 8'h00);
      idle_mode <= 1'b0;
      stop_mode <= 1'b1;
      filt(3'h5, 1'b1, 32, 2 * 32 + 2, 1);
      rd(STAT_ADDR, d);
      chk(d, 1 << STAT_RUN_BIT);
      stop_mode <= 1'b0;
      test_done();
   end

   // Budget covers the longest divider runs with margin.
   initial begin
      repeat (80000) @(posedge core_clk);
      err_total++;
      test_done();
   end
endmodule : einf_top_tb
`default_nettype wire
